//--- lpd_driver.sv
// Serial shift-in dual-bank LED PWM driver core
`timescale 1ns/10ps
`default_nettype none
module lpd_driver (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clock,
  input wire logic serial_data_in,
  input wire logic bank_select,
  input wire logic latch_strobe_n,
  input wire logic grayscale_clock,
  input wire logic output_enable_n,
  output logic serial_data_out,
  output logic [lpd_pkg::CH_COUNT-1:0] channel_output,
  output logic [lpd_pkg::CH_COUNT-1:0] channel_level
);
  import lpd_pkg::*;

  // ----------------------------------------
  // Shift chains on the shift clock
  // ----------------------------------------
  logic [SIX_CHAIN-1:0] six_bit_bank_r;
  logic [SIX_CHAIN-1:0] six_bit_bank_nxt;
  logic [EIGHT_CHAIN-1:0] eight_bit_bank_r;
  logic [EIGHT_CHAIN-1:0] eight_bit_bank_nxt;
  logic serial_data_out_r;
  logic serial_data_out_nxt;

  always_comb begin
    six_bit_bank_nxt = six_bit_bank_r;
    eight_bit_bank_nxt = eight_bit_bank_r;
    if (bank_select) begin
      eight_bit_bank_nxt = {eight_bit_bank_r[EIGHT_CHAIN-2:0], serial_data_in};
    end else begin
      six_bit_bank_nxt = {six_bit_bank_r[SIX_CHAIN-2:0], serial_data_in};
    end
    serial_data_out_nxt = bank_select ? eight_bit_bank_nxt[EIGHT_CHAIN-1] :
                             six_bit_bank_nxt[SIX_CHAIN-1];
  end

  always_ff @(posedge shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      six_bit_bank_r <= SIX_RST;
      eight_bit_bank_r <= EIGHT_RST;
      serial_data_out_r <= 1'b0;
    end else begin
      six_bit_bank_r <= six_bit_bank_nxt;
      eight_bit_bank_r <= eight_bit_bank_nxt;
      serial_data_out_r <= serial_data_out_nxt;
    end
  end

  assign serial_data_out = serial_data_out_r;

  // ----------------------------------------
  // Pin synchronisers on the system clock
  // ----------------------------------------
  logic [2:0] lat_sync_r;
  logic [2:0] lat_sync_nxt;
  logic [2:0] gck_sync_r;
  logic [2:0] gck_sync_nxt;
  logic [1:0] oe_sync_r;
  logic [1:0] oe_sync_nxt;
  logic latch_fall;
  logic gck_rise;

  always_comb begin
    lat_sync_nxt = {lat_sync_r[1:0], latch_strobe_n};
    gck_sync_nxt = {gck_sync_r[1:0], grayscale_clock};
    oe_sync_nxt = {oe_sync_r[0], output_enable_n};
    latch_fall = lat_sync_r[2] & ~lat_sync_r[1];
    gck_rise = gck_sync_r[1] & ~gck_sync_r[2];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_sync_r <= SYNC_RST;
      gck_sync_r <= SYNC_RST;
      oe_sync_r <= SYNC_RST_HI[1:0];
    end else begin
      lat_sync_r <= lat_sync_nxt;
      gck_sync_r <= gck_sync_nxt;
      oe_sync_r <= oe_sync_nxt;
    end
  end

  // ----------------------------------------
  // Data latches and PWM counter
  // ----------------------------------------
  logic [SIX_CHAIN-1:0] six_latch_r;
  logic [SIX_CHAIN-1:0] six_latch_nxt;
  logic [EIGHT_CHAIN-1:0] eight_latch_r;
  logic [EIGHT_CHAIN-1:0] eight_latch_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  always_comb begin
    six_latch_nxt = six_latch_r;
    eight_latch_nxt = eight_latch_r;
    count_nxt = count_r;
    if (latch_fall) begin
      six_latch_nxt = six_bit_bank_r;
      eight_latch_nxt = eight_bit_bank_r;
    end
    if (gck_rise) begin
      count_nxt = count_r + CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      six_latch_r <= SIX_RST;
      eight_latch_r <= EIGHT_RST;
      count_r <= CNT_RST;
    end else begin
      six_latch_r <= six_latch_nxt;
      eight_latch_r <= eight_latch_nxt;
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------
  // Nonconsecutive counter and comparators
  // ----------------------------------------
  logic [EIGHT_W-1:0] cnt8_rev;
  logic [SIX_W-1:0] cnt6_rev;
  logic [CH_COUNT-1:0] pwm_on;
  logic counter_full;

  genvar b;
  generate
    for (b = 0; b < EIGHT_W; b++) begin : g_rev8
      assign cnt8_rev[b] = count_r[EIGHT_W-1-b];
    end
    for (b = 0; b < SIX_W; b++) begin : g_rev6
      assign cnt6_rev[b] = count_r[CNT_W-1-b];
    end
  endgenerate

  assign counter_full = (cnt8_rev == EIGHT_FULL) | (cnt6_rev == SIX_FULL);

  genvar c;
  generate
    for (c = 0; c < CH_COUNT; c++) begin : g_ch
      logic [EIGHT_W-1:0] g8;
      logic [SIX_W-1:0] g6;
      assign g8 = eight_latch_r[c*EIGHT_W +: EIGHT_W];
      assign g6 = six_latch_r[c*SIX_W +: SIX_W];
      assign pwm_on[c] = (g8 > cnt8_rev) & (g6 > cnt6_rev) & ~counter_full;
    end
  endgenerate

  // ----------------------------------------
  // Channel outputs
  // ----------------------------------------
  logic [CH_COUNT-1:0] out_r;
  logic [CH_COUNT-1:0] out_nxt;
  logic [CH_COUNT-1:0] level_r;
  logic [CH_COUNT-1:0] level_nxt;

  always_comb begin
    out_nxt = oe_sync_r[1] ? CH_OFF : pwm_on;
    level_nxt = ~out_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= CH_OFF;
      level_r <= LEVEL_OFF;
    end else begin
      out_r <= out_nxt;
      level_r <= level_nxt;
    end
  end

  assign channel_output = out_r;
  assign channel_level = level_r;

endmodule : lpd_driver
`default_nettype wire

//--- lpd_pkg.sv
// Constants shared by the serial LED PWM driver core
package lpd_pkg;
  localparam int CH_COUNT = 24;
  localparam int SIX_W = 6;
  localparam int EIGHT_W = 8;
  localparam int SIX_CHAIN = CH_COUNT * SIX_W;
  localparam int EIGHT_CHAIN = CH_COUNT * EIGHT_W;
  localparam int CNT_W = SIX_W + EIGHT_W;
  localparam logic [SIX_W-1:0] SIX_FULL = 6'h3F;
  localparam logic [EIGHT_W-1:0] EIGHT_FULL = 8'hFF;
  localparam logic [SIX_CHAIN-1:0] SIX_RST = '0;
  localparam logic [EIGHT_CHAIN-1:0] EIGHT_RST = '0;
  localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  localparam logic [CH_COUNT-1:0] CH_OFF = 24'h000000;
  localparam logic [CH_COUNT-1:0] LEVEL_OFF = 24'hFFFFFF;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [2:0] SYNC_RST_HI = 3'h7;
endpackage : lpd_pkg

//--- lpd_driver_chk.sv
// Port assertions for the LED PWM driver
`timescale 1ns/10ps
`default_nettype none
module lpd_driver_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clock,
  input wire logic latch_strobe_n,
  input wire logic grayscale_clock,
  input wire logic output_enable_n,
  input wire logic serial_data_out,
  input wire logic [lpd_pkg::CH_COUNT-1:0] channel_output,
  input wire logic [lpd_pkg::CH_COUNT-1:0] channel_level
);
  import lpd_pkg::*;
  logic seen_r;
  logic seen_nxt;
  always_comb seen_nxt = seen_r | !latch_strobe_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) seen_r <= 1'b0;
    else seen_r <= seen_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  level_inverse_a: assert property (channel_level == ~channel_output)
    else $error("level not inverse");
  enable_off_a: assert property (output_enable_n [*5] |-> channel_output == CH_OFF)
    else $error("enable ignored");
  quiet_hold_a:
    assert property (($stable(grayscale_clock) && $stable(latch_strobe_n)
      && $stable(output_enable_n)) [*6] |-> $stable(channel_output)) else $error("output moved");
  reset_off_a:
    assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n [*2] |-> channel_output == CH_OFF)
    else $error("reset outputs");
  reset_serial_data_out_a:
    assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n [*2] |-> !serial_data_out)
    else $error("reset serial out");
  idle_serial_data_out_a: assert property ((!shift_clock) [*2] |-> $stable(serial_data_out))
    else $error("serial out moved");
  no_latch_a: assert property (!seen_r |-> channel_output == CH_OFF)
    else $error("on before latch");
  release_off_a: assert property ($rose(rst_n) |-> (channel_output == CH_OFF) [*3])
    else $error("on after release");
  cover property (seen_r && |channel_output);
  cover property (output_enable_n [*5]);
  cover property ($rose(|channel_output));
endmodule : lpd_driver_chk
bind lpd_driver lpd_driver_chk lpd_driver_chk_i (.*);
`default_nettype wire

//--- lpd_host.sv
// Host model that clocks grayscale bits into the driver
`timescale 1ns/10ps
`default_nettype none
module lpd_host (
  input wire logic link_clk,
  input wire logic serial_data_out,
  output logic shift_clock,
  output logic serial_data_in,
  output logic bank_select
);
  logic gate_r = 1'b0;
  assign shift_clock = link_clk & gate_r;
  initial serial_data_in = 1'b0;
  initial bank_select = 1'b0;
  task automatic send(input logic [191:0] d, input int n, input logic b, output logic [191:0] o);
    bank_select = b;
    o = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge link_clk);
      o = {o[190:0], serial_data_out};
      serial_data_in = d[i];
      gate_r = 1'b1;
    end
    @(negedge link_clk);
    gate_r = 1'b0;
    serial_data_in = ~serial_data_in;
  endtask : send
endmodule : lpd_host
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the LED PWM driver core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module tb_top;
  import lpd_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b1, link_clk = 1'b0, latch_strobe_n = 1'b1;
  logic grayscale_clock = 1'b0, output_enable_n = 1'b0;
  logic shift_clock, serial_data_in, bank_select, serial_data_out;
  logic [CH_COUNT-1:0] channel_output, channel_level, expv;
  logic [CH_COUNT-1:0] q[$];
  logic [EIGHT_CHAIN-1:0] d8, sob;
  logic [SIX_CHAIN-1:0] d6;
  int err_total = 0, num_checks = 0;
  event look;
  always #10 sys_clk = ~sys_clk;
  initial begin #13; forever #32 link_clk = ~link_clk; end
  lpd_driver lpd_driver_i (.*);
  lpd_host lpd_host_i (.*);
  function automatic logic [CH_COUNT-1:0] pwm(input logic [CNT_W-1:0] c);
    logic [7:0] r8;
    logic [5:0] r6;
    r8 = {<<{c[7:0]}};
    r6 = {<<{c[13:8]}};
    for (int k = 0; k < CH_COUNT; k++) pwm[k] = d8[8*k+:8] > r8 && d6[6*k+:6] > r6
      && r8 != EIGHT_FULL && r6 != SIX_FULL;
  endfunction : pwm
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic expect_out(input logic [CH_COUNT-1:0] e);
    q.push_back(e);
    ->look;
  endtask : expect_out
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(look) begin
    expv = q.pop_front();
    `CHK(channel_output, expv)
    `CHK(channel_level, ~expv)
  end
  initial begin
    void'($urandom(53052));
    #1 rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(3);
    expect_out(CH_OFF);
    $display("reset test done");
    for (int i = 0; i < 6; i++) d8[32*i+:32] = $urandom;
    for (int i = 0; i < 6; i++) d6[24*i+:24] = $urandom;
    lpd_host_i.send({48'h0, d6}, SIX_CHAIN, 1'b0, sob);
    lpd_host_i.send(d8, EIGHT_CHAIN, 1'b1, sob);
    cyc(2);
    latch_strobe_n = 1'b0;
    cyc(3);
    latch_strobe_n = 1'b1;
    cyc(4);
    for (int c = 0; c <= 256; c++) begin
      expect_out(pwm(c[13:0]));
      grayscale_clock = 1'b1;
      cyc(3);
      grayscale_clock = 1'b0;
      cyc(4);
    end
    $display("pwm sweep done");
    output_enable_n = 1'b1;
    cyc(6);
    expect_out(CH_OFF);
    output_enable_n = 1'b0;
    cyc(6);
    expect_out(pwm(14'h0101));
    $display("enable test done");
    lpd_host_i.send(d8, 8, 1'b1, sob);
    `CHK(sob[7:0], d8[191:184])
    $display("cascade test done");
    rst_n = 1'b0;
    cyc(3);
    expect_out(CH_OFF);
    rst_n = 1'b1;
    cyc(3);
    latch_strobe_n = 1'b0;
    cyc(3);
    latch_strobe_n = 1'b1;
    cyc(4);
    expect_out(CH_OFF);
    $display("second reset test done");
    report_and_stop();
  end
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
